// *** verilog/ai_scale_pkg.sv ***
package ai_scale_pkg;
    localparam int          AW = 12;
    localparam int          DW = 32;
    localparam int          RW = 16;
    localparam int          CW = 12;
    // register indexes; byte address = index * 4
    localparam logic [9:0]  IX_FUNC    = 10'h300;
    localparam logic [9:0]  IX_VBIAS   = 10'h302;
    localparam logic [9:0]  IX_CBIAS   = 10'h303;
    localparam logic [9:0]  IX_VBMODE  = 10'h304;
    localparam logic [9:0]  IX_CBMODE  = 10'h308;
    localparam logic [9:0]  IX_REVEN   = 10'h30a;
    localparam logic [9:0]  IX_VGAIN   = 10'h30b;
    localparam logic [9:0]  IX_CGAIN   = 10'h30c;
    localparam logic [9:0]  IX_ADDEN   = 10'h312;
    localparam logic [9:0]  IX_OVRD    = 10'h350;
    localparam logic [9:0]  IX_TGTSRC  = 10'h340;
    localparam logic [9:0]  IX_CMPSRC  = 10'h341;
    localparam logic [9:0]  IX_MAXF    = 10'h342;
    localparam logic [9:0]  IX_CMPMON  = 10'h343;
    localparam logic [9:0]  IX_STATUS  = 10'h344;
    localparam logic [15:0] RST_FUNC   = 16'h0001;
    localparam logic [15:0] RST_GAIN   = 16'h03e8;
    localparam logic [15:0] RST_MAXF   = 16'h1770;
    localparam logic [15:0] RST_ZERO   = 16'h0000;
    // function codes
    localparam logic [15:0] FN_NONE = 16'h0000;
    localparam logic [15:0] FN_FREQ = 16'h0001;
    localparam logic [15:0] FN_PIDT = 16'h0004;
    localparam logic [15:0] FN_PIDF = 16'h0005;
    localparam logic [15:0] FN_PTC  = 16'h0006;
    localparam logic [15:0] FN_RTD  = 16'h000b;
    localparam logic [15:0] FN_AUX  = 16'h000c;
    localparam logic [15:0] FN_COMP = 16'h000d;
    localparam int          NROUTE  = 7;
    // bias modes
    localparam logic [15:0] BM_NONE = 16'h0000;
    localparam logic [15:0] BM_LE   = 16'h0001;
    localparam logic [15:0] BM_GE   = 16'h0002;
    localparam logic [15:0] BM_ABS  = 16'h0003;
    localparam logic [15:0] BM_CTR  = 16'h0004;
    localparam logic [15:0] ONE     = 16'h0001;
    // permille full scale; adc code full span
    localparam logic signed [31:0] FULL   = 32'sd1000;
    localparam int                 CSHIFT = 12;
endpackage

// *** verilog/analog_input_scaling.sv ***
// Functional notes
// - function code routes input to one use
// - mode switch picks voltage or current set
// - one function code serves both modes
// - compensation needs source 1, value monitored
// - full span maps onto zero..max frequency
// - per-mode signed bias, default zero
// - scaling settings except added sum and max frequency act only when override zero
// - per-mode bias mode decodes codes 0..4
// - reverse disabled rejects negative frequency
// - reverse enabled gives input direction ownership
// - reverse needs enable, center mode, negative gain
// - added sum negative follows same reverse test
// - per-mode signed gain, default 100 percent
`timescale 1ns/1ns
`default_nettype none
module analog_input_scaling (
    input  wire logic                       mclk,
    input  wire logic                       resetn,
    input  wire logic [ai_scale_pkg::AW-1:0] addr,
    input  wire logic [ai_scale_pkg::DW-1:0] wdata,
    input  wire logic                       wr,
    input  wire logic                       rd,
    output logic      [ai_scale_pkg::DW-1:0] rdata,
    input  wire logic [ai_scale_pkg::CW-1:0] adc_code,
    input  wire logic                       current_input_mode,
    input  wire logic signed [ai_scale_pkg::RW-1:0] addend,
    output logic      [ai_scale_pkg::RW-1:0] freq_cmd,
    output logic signed [ai_scale_pkg::RW-1:0] func_value,
    output logic      [ai_scale_pkg::NROUTE-1:0] route,
    output logic                            pid_target_ok,
    output logic                            dir_from_input,
    output logic                            run_reverse,
    output logic                            neg_rejected
);
    import ai_scale_pkg::*;
    localparam logic [RW-1:0] TGT_EXT = 16'h0002;

    logic [RW-1:0] func_q, vbias_q, cbias_q, vbm_q, cbm_q, reven_q;
    logic [RW-1:0] vgain_q, cgain_q, adden_q, ovrd_q, tgtsrc_q, cmpsrc_q, maxf_q;
    logic [RW-1:0] cmpmon_q, freq_q;
    logic [DW-1:0] rdata_q;
    logic [CW-1:0] code_s1_q, code_s2_q;
    logic [CW-1:0] code_s3_q, code_q;
    logic          mode_s1_q, mode_s2_q;
    logic signed [RW-1:0] fval_q;
    logic [NROUTE-1:0]    route_q;
    logic          tgt_q, dir_q, rev_q, rej_q;
    logic [9:0]    idx;
    logic          hit;

    assign idx = addr[AW-1:2];
    assign hit = (addr[1:0] == 2'h0);

    // register writes
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            func_q   <= RST_FUNC;
            vbias_q  <= RST_ZERO;
            cbias_q  <= RST_ZERO;
            vbm_q    <= RST_ZERO;
            cbm_q    <= RST_ZERO;
            reven_q  <= RST_ZERO;
            vgain_q  <= RST_GAIN;
            cgain_q  <= RST_GAIN;
            adden_q  <= RST_ZERO;
            ovrd_q   <= RST_ZERO;
            tgtsrc_q <= RST_ZERO;
            cmpsrc_q <= RST_ZERO;
            maxf_q   <= RST_MAXF;
        end else if (wr && hit) begin
            case (idx)
                IX_FUNC:   func_q   <= wdata[RW-1:0];
                IX_VBIAS:  vbias_q  <= wdata[RW-1:0];
                IX_CBIAS:  cbias_q  <= wdata[RW-1:0];
                IX_VBMODE: vbm_q    <= wdata[RW-1:0];
                IX_CBMODE: cbm_q    <= wdata[RW-1:0];
                IX_REVEN:  reven_q  <= wdata[RW-1:0];
                IX_VGAIN:  vgain_q  <= wdata[RW-1:0];
                IX_CGAIN:  cgain_q  <= wdata[RW-1:0];
                IX_ADDEN:  adden_q  <= wdata[RW-1:0];
                IX_OVRD:   ovrd_q   <= wdata[RW-1:0];
                IX_TGTSRC: tgtsrc_q <= wdata[RW-1:0];
                IX_CMPSRC: cmpsrc_q <= wdata[RW-1:0];
                IX_MAXF:   maxf_q   <= wdata[RW-1:0];
                default: ;
            endcase
        end
    end

    // read data, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= '0;
        end else if (rd && hit) begin
            case (idx)
                IX_FUNC:   rdata_q <= {16'h0000, func_q};
                IX_VBIAS:  rdata_q <= {16'h0000, vbias_q};
                IX_CBIAS:  rdata_q <= {16'h0000, cbias_q};
                IX_VBMODE: rdata_q <= {16'h0000, vbm_q};
                IX_CBMODE: rdata_q <= {16'h0000, cbm_q};
                IX_REVEN:  rdata_q <= {16'h0000, reven_q};
                IX_VGAIN:  rdata_q <= {16'h0000, vgain_q};
                IX_CGAIN:  rdata_q <= {16'h0000, cgain_q};
                IX_ADDEN:  rdata_q <= {16'h0000, adden_q};
                IX_OVRD:   rdata_q <= {16'h0000, ovrd_q};
                IX_TGTSRC: rdata_q <= {16'h0000, tgtsrc_q};
                IX_CMPSRC: rdata_q <= {16'h0000, cmpsrc_q};
                IX_MAXF:   rdata_q <= {16'h0000, maxf_q};
                IX_CMPMON: rdata_q <= {16'h0000, cmpmon_q};
                IX_STATUS: rdata_q <= {16'h0000, freq_q};
                default:   rdata_q <= '0;
            endcase
        end else begin
            rdata_q <= '0;
        end
    end

    // converter and dip switch live outside this clock
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            code_s1_q <= '0;
            code_s2_q <= '0;
            mode_s1_q <= 1'b0;
            mode_s2_q <= 1'b0;
        end else begin
            code_s1_q <= adc_code;
            code_s2_q <= code_s1_q;
            mode_s1_q <= current_input_mode;
            mode_s2_q <= mode_s1_q;
        end
    end

    // a word caught mid-change can mix old and new bits: take a code only
    // once two later samples agree; a code moving every cycle holds its last
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            code_s3_q <= '0;
            code_q    <= '0;
        end else begin
            code_s3_q <= code_s2_q;
            if (code_s2_q == code_s3_q) begin
                code_q <= code_s3_q;
            end
        end
    end

    // active parameter set
    logic [RW-1:0]        a_bm;
    logic signed [RW-1:0] a_bias, a_gain;
    logic                 scal_on, rev_en, rev_ok;
    assign a_bm    = mode_s2_q ? cbm_q : vbm_q;
    assign a_bias  = mode_s2_q ? $signed(cbias_q) : $signed(vbias_q);
    assign a_gain  = mode_s2_q ? $signed(cgain_q) : $signed(vgain_q);
    assign scal_on = (ovrd_q == RST_ZERO);
    assign rev_en  = scal_on && (reven_q == ONE);
    assign rev_ok  = rev_en && (a_bm == BM_CTR) && a_gain[RW-1];

    // bias, then gain, then optional sum
    // full code reaches full scale, so max frequency is reachable
    localparam logic signed [31:0] SPAN = (32'sd1 <<< CW) - 32'sd1;
    logic signed [31:0] x, b, y, z, s, mag, lim;
    logic [31:0]        fw;
    always_comb begin
        x = ($signed(32'(code_q)) * FULL) / SPAN;
        b = 32'(a_bias);
        y = x;
        if (scal_on) begin
            case (a_bm)
                BM_NONE: y = x;
                BM_LE:   y = (x + b < 0) ? 32'sd0 : x + b;
                BM_GE:   y = (x + b < b) ? b : x + b;
                BM_ABS:  y = x - ((b < 0) ? -b : b);
                BM_CTR:  y = x - b;
                default: y = x;
            endcase
            z = (y * 32'(a_gain)) / FULL;
        end else begin
            z = x;
        end
        s = (adden_q == ONE) ? z + 32'(addend) : z;
        mag = (s < 0) ? -s : s;
        lim = (mag > FULL) ? FULL : mag;
        fw  = 32'((lim * 32'(maxf_q)) / FULL);
    end

    // routing and direction
    logic neg;
    assign neg = (s < 0);

    // one code for both modes: mode bit not used here
    localparam logic [RW-1:0] ROUTE_CODE [NROUTE] = '{FN_FREQ, FN_PIDT, FN_PIDF, FN_PTC,
                                                     FN_RTD, FN_AUX, FN_COMP};
    for (genvar g = 0; g < NROUTE; g++) begin : g_route
        always_ff @(posedge mclk or negedge resetn) begin
            if (!resetn) begin
                route_q[g] <= 1'b0;
            end else begin
                route_q[g] <= (func_q == ROUTE_CODE[g]);
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            fval_q  <= '0;
            tgt_q   <= 1'b0;
        end else begin
            fval_q  <= (s > FULL) ? RW'(FULL) : (s < -FULL) ? RW'(-FULL) : RW'(s);
            tgt_q   <= (func_q == FN_PIDT || func_q == FN_FREQ)
                       && (tgtsrc_q == TGT_EXT);
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            freq_q <= '0;
            dir_q  <= 1'b0;
            rev_q  <= 1'b0;
            rej_q  <= 1'b0;
        end else begin
            dir_q <= rev_en;
            rev_q <= neg && rev_ok;
            rej_q <= neg && !rev_ok;
            freq_q <= (neg && !rev_ok) ? RST_ZERO : fw[RW-1:0];
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cmpmon_q <= '0;
        end else begin
            cmpmon_q <= (func_q == FN_COMP && cmpsrc_q == ONE) ?
                        (fval_q) : RST_ZERO;
        end
    end

    assign rdata          = rdata_q;
    assign freq_cmd       = freq_q;
    assign func_value     = fval_q;
    assign route          = route_q;
    assign pid_target_ok  = tgt_q;
    assign dir_from_input = dir_q;
    assign run_reverse    = rev_q;
    assign neg_rejected   = rej_q;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    rd_func_a: assert property (rd && addr == {IX_FUNC, 2'b00} |=>
        rdata == {16'h0000, $past(func_q)}) else $error("function code read wrong");
    route_freq_a: assert property (func_q == FN_FREQ |=> route == 7'h01)
        else $error("frequency route wrong");
    rev_cause_a: assert property (run_reverse |->
        $past(a_bm) == BM_CTR && $past(a_gain[RW-1]) && $past(reven_q) == ONE)
        else $error("reverse without all three conditions");
    rev_off_a: assert property (reven_q != ONE |=> !run_reverse)
        else $error("reverse while disabled");
    dir_owner_a: assert property (reven_q == ONE && ovrd_q == RST_ZERO |=>
        dir_from_input) else $error("direction not taken from input");
    override_a: assert property (ovrd_q != RST_ZERO |=>
        !dir_from_input && !run_reverse) else $error("override ignored");
    freq_clamp_a: assert property (freq_cmd <= $past(maxf_q))
        else $error("frequency above maximum");
    comp_mon_a: assert property (func_q != FN_COMP || cmpsrc_q != ONE |=>
        cmpmon_q == RST_ZERO) else $error("compensation monitor stale");
    reject_a: assert property (neg_rejected |-> !run_reverse && freq_cmd == RST_ZERO)
        else $error("negative frequency not rejected");
    route_none_a: assert property (func_q == FN_NONE |=> route == '0)
        else $error("route set for no function");
    tgt_src_a: assert property (tgtsrc_q != TGT_EXT |=> !pid_target_ok)
        else $error("pid target without external source");
    fval_range_a: assert property (func_value <= FULL && func_value >= -FULL)
        else $error("function value outside clamp");

    neg_reject_a: assert property (neg && reven_q != ONE |=>
        neg_rejected && freq_cmd == RST_ZERO) else $error("negative accepted while disabled");
    sum_rev_a: assert property (adden_q == ONE && neg && rev_ok |=>
        run_reverse && !neg_rejected) else $error("negative sum not reversed");
    gain_sign_a: assert property (neg && rev_en && (a_bm != BM_CTR || !a_gain[RW-1]) |=>
        !run_reverse && neg_rejected) else $error("reverse without center mode and gain");
    mon_value_a: assert property (func_q == FN_COMP && cmpsrc_q == ONE |=>
        cmpmon_q == $past(fval_q)) else $error("compensation monitor wrong");
    dir_off_a: assert property (reven_q != ONE |=> !dir_from_input)
        else $error("direction taken while reverse disabled");
    status_rd_a: assert property (rd && addr == {IX_STATUS, 2'b00} |=>
        rdata == {16'h0000, $past(freq_cmd)}) else $error("status read wrong");
    rev_dir_a: assert property (run_reverse |-> dir_from_input)
        else $error("reverse without input direction");
    ovrd_pos_a: assert property (ovrd_q != RST_ZERO && adden_q != ONE |=> !neg_rejected)
        else $error("override result negative");
    le_pos_a: assert property (scal_on && a_bm == BM_LE && adden_q != ONE && !a_gain[RW-1]
        |=> !neg_rejected) else $error("bias floor gave negative result");

    rev_run_c: cover property (run_reverse ##1 !run_reverse);
    sum_rev_c: cover property (adden_q == ONE && run_reverse);
    override_c: cover property (ovrd_q != RST_ZERO && freq_cmd != RST_ZERO);
    reject_c: cover property (neg_rejected && reven_q == RST_ZERO);
    cur_mode_c: cover property (mode_s2_q && route[0] && freq_cmd != RST_ZERO);
endmodule // analog_input_scaling
`default_nettype wire

// *** bench/analog_source_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module analog_source_model (
    input  wire logic        mclk,
    input  wire logic [11:0] level,
    input  wire logic        use_current,
    output logic      [11:0] adc_code,
    output logic             current_input_mode
);
    // levels change only on an edge; low levels left to the scenario, unwise in noise
    always_ff @(posedge mclk) begin
        adc_code           <= level;
        current_input_mode <= use_current;
    end
endmodule // analog_source_model
`default_nettype wire

// *** bench/analog_input_scaling_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
module analog_input_scaling_bench;
    import ai_scale_pkg::*;
    logic              mclk = 1'b0;
    logic              resetn = 1'b0;
    logic [AW-1:0]     addr = '0;
    logic [DW-1:0]     wdata = '0;
    logic              wr = 1'b0;
    logic              rd = 1'b0;
    logic [11:0]       level = 12'h800;
    logic              use_cur = 1'b0;
    logic [RW-1:0]     addend = '0;
    logic [DW-1:0]     rdata;
    logic [11:0]       adc_code;
    logic              cur_mode;
    logic [RW-1:0]     freq_cmd;
    logic [RW-1:0]     func_value;
    logic [NROUTE-1:0] route;
    logic              tgt_ok, dir_in, run_rev, neg_rej;
    int                n_mismatch = 0;
    int                checks_done = 0;
    int                cycles = 0;
    logic [9:0]  rix [9] = '{IX_FUNC, IX_VBIAS, IX_CBIAS, IX_VBMODE, IX_CBMODE, IX_REVEN,
                             IX_VGAIN, IX_CGAIN, 10'h301};
    logic [15:0] rval [9] = '{RST_FUNC, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
                              RST_GAIN, RST_GAIN, 16'h0000};
    logic [15:0] fcode [9] = '{FN_NONE, FN_FREQ, FN_PIDT, FN_PIDF, FN_PTC, FN_RTD, FN_AUX,
                               FN_COMP, 16'h0002};
    logic [6:0]  fhot [9] = '{7'h00, 7'h01, 7'h02, 7'h04, 7'h08, 7'h10, 7'h20, 7'h40, 7'h00};
    // x=500, bias -600, gain 100 percent, per bias mode 0..4
    logic [15:0] bmf [5] = '{16'd3000, 16'd0, 16'd0, 16'd0, 16'd6000};
    logic [15:0] bmv [5] = '{16'd500, 16'd0, 16'hff9c, 16'hff9c, 16'd1000};
    logic        bmn [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};

    always #4 mclk = ~mclk;

    analog_source_model u_analog_source_model (.mclk(mclk), .level(level), .use_current(use_cur),
        .adc_code(adc_code), .current_input_mode(cur_mode));

    analog_input_scaling u_analog_input_scaling (.mclk(mclk), .resetn(resetn), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .adc_code(adc_code),
        .current_input_mode(cur_mode), .addend(addend), .freq_cmd(freq_cmd),
        .func_value(func_value), .route(route), .pid_target_ok(tgt_ok),
        .dir_from_input(dir_in), .run_reverse(run_rev), .neg_rejected(neg_rej));

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // hang guard well above the few hundred cycles the tests need
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch = n_mismatch + 1;
            end_sim();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [9:0] ix, input logic [15:0] v);
        @(posedge mclk);
        addr  <= {ix, 2'b00};
        wdata <= {16'h0000, v};
        wr    <= 1'b1;
        @(posedge mclk);
        wr    <= 1'b0;
    endtask

    task automatic rd_chk(input logic [9:0] ix, input logic [15:0] exp);
        @(posedge mclk);
        addr <= {ix, 2'b00};
        rd   <= 1'b1;
        @(posedge mclk);
        rd   <= 1'b0;
        #1;
        chk(rdata, {16'h0000, exp});
    endtask

    task automatic settle();
        repeat (8) @(posedge mclk);
        #1;
    endtask

    task automatic src(input logic [11:0] lv, input logic cur, input logic [15:0] add);
        @(posedge mclk);
        level   <= lv;
        use_cur <= cur;
        addend  <= add;
    endtask

    task automatic outs(input logic [15:0] f, input logic [15:0] v);
        settle();
        chk({16'h0000, freq_cmd}, {16'h0000, f});
        chk({16'h0000, func_value}, {16'h0000, v});
    endtask

    initial begin
        repeat (12) @(posedge mclk);
        resetn <= 1'b1;
        for (int i = 0; i < 9; i++) rd_chk(rix[i], rval[i]);
        for (int i = 0; i < 9; i++) begin
            wr_reg(IX_FUNC, fcode[i]);
            settle();
            chk({25'h0, route}, {25'h0, fhot[i]});
        end
        wr_reg(IX_FUNC, FN_FREQ);
        src(12'h000, 1'b0, 16'h0000);
        outs(16'd0, 16'd0);
        src(12'hfff, 1'b0, 16'h0000);
        outs(16'd6000, 16'd1000);
        src(12'h800, 1'b0, 16'h0000);
        wr_reg(IX_VGAIN, 16'h01f4);
        outs(16'd1500, 16'd250);
        src(12'h800, 1'b1, 16'h0000);
        outs(16'd3000, 16'd500);
        chk({25'h0, route}, 32'h1);
        wr_reg(IX_CBIAS, 16'hfda8);
        wr_reg(IX_CBMODE, BM_CTR);
        outs(16'd6000, 16'd1000);
        src(12'h800, 1'b0, 16'h0000);
        wr_reg(IX_VGAIN, RST_GAIN);
        wr_reg(IX_VBIAS, 16'hfda8);
        for (int m = 0; m < 5; m++) begin
            wr_reg(IX_VBMODE, 16'(m));
            outs(bmf[m], bmv[m]);
            chk({31'h0, neg_rej}, {31'h0, bmn[m]});
        end
        wr_reg(IX_VBIAS, 16'h00c8);
        wr_reg(IX_VGAIN, 16'hfc18);
        outs(16'd0, 16'hfed4);
        chk({30'h0, neg_rej, run_rev}, 32'h2);
        wr_reg(IX_REVEN, ONE);
        outs(16'd1800, 16'hfed4);
        chk({29'h0, dir_in, neg_rej, run_rev}, 32'h5);
        wr_reg(IX_VBMODE, BM_ABS);
        outs(16'd0, 16'hfed4);
        chk({31'h0, run_rev}, 32'h0);
        wr_reg(IX_OVRD, ONE);
        outs(16'd3000, 16'd500);
        chk({31'h0, dir_in}, 32'h0);
        rd_chk(IX_STATUS, 16'd3000);
        wr_reg(IX_OVRD, RST_ZERO);
        wr_reg(IX_VBMODE, BM_NONE);
        wr_reg(IX_VGAIN, RST_GAIN);
        wr_reg(IX_REVEN, RST_ZERO);
        wr_reg(IX_ADDEN, ONE);
        src(12'h800, 1'b0, 16'hfd44);
        outs(16'd0, 16'hff38);
        chk({31'h0, neg_rej}, 32'h1);
        wr_reg(IX_VBMODE, BM_CTR);
        wr_reg(IX_VGAIN, 16'hfc18);
        wr_reg(IX_REVEN, ONE);
        outs(16'd6000, 16'hfc18);
        chk({30'h0, neg_rej, run_rev}, 32'h1);
        wr_reg(IX_VBMODE, BM_NONE);
        wr_reg(IX_VGAIN, RST_GAIN);
        src(12'h800, 1'b0, 16'h0000);
        wr_reg(IX_FUNC, FN_PIDT);
        wr_reg(IX_TGTSRC, 16'h0002);
        settle();
        chk({31'h0, tgt_ok}, 32'h1);
        wr_reg(IX_TGTSRC, RST_ZERO);
        settle();
        chk({31'h0, tgt_ok}, 32'h0);
        wr_reg(IX_FUNC, FN_COMP);
        wr_reg(IX_CMPSRC, ONE);
        wr_reg(IX_CMPMON, 16'h1234);
        settle();
        rd_chk(IX_CMPMON, 16'd500);
        wr_reg(IX_CMPSRC, RST_ZERO);
        settle();
        rd_chk(IX_CMPMON, 16'd0);
        end_sim();
    end
endmodule // analog_input_scaling_bench
`default_nettype wire
